/* include/nvm_spi_defs.svh */
// Constants for the serial memory port: command codes, status bit positions, the fixed status value and sizes.
// Assumes it is included by its bare name from the design file.
`ifndef NVM_SPI_DEFS_SVH
`define NVM_SPI_DEFS_SVH

`define CMD_WRITE_LATCH_SET 8'h06
`define CMD_WRITE_LATCH_CLR 8'h04
`define CMD_READ_STATUS     8'h05
`define CMD_WRITE_STATUS    8'h01
`define CMD_READ_MEM        8'h03
`define CMD_FAST_READ       8'h0B
`define CMD_WRITE_MEM       8'h02
`define CMD_READ_IDENT      8'h9F

`define SR_PROT_EN_BIT      7
`define SR_BLK1_BIT         3
`define SR_BLK0_BIT         2
`define SR_LATCH_BIT        1
`define SR_FIXED_VALUE      8'h40

`define ADDR_BITS           17
`define ADDR_BYTES          2'h3
`define BYTE_LAST_BIT       3'h7
`define IDENT_DEFAULT       24'hA55A01  // Arbitrary value.

`endif

/* include/nvm_spi_pkg.sv */
// Types shared by the serial memory port.
// Assumes the defs header sits on the include path.
`default_nettype none

package nvm_spi_pkg;
  typedef enum logic [2:0]
  {
    ST_CMD    = 3'b000,
    ST_ADDR   = 3'b001,
    ST_DUMMY  = 3'b010,
    ST_WDATA  = 3'b011,
    ST_RDATA  = 3'b100,
    ST_WSTAT  = 3'b101,
    ST_IGNORE = 3'b110
  } port_state_t;
endpackage : nvm_spi_pkg

`default_nettype wire

/* hw/serial_nv_memory_spi_port.sv */
// Serial peripheral port of a byte-wide nonvolatile memory, with the array held in flip-flops.
// Assumes all pins come from the bus master asynchronously to mclk and that the serial
// clock is well below a quarter of mclk so every edge is seen after synchronisation.
`include "nvm_spi_defs.svh"
`default_nettype none

module serial_nv_memory_spi_port #(
  parameter int          ADDR_W    = `ADDR_BITS,
  parameter logic [23:0] IDENT_VAL = `IDENT_DEFAULT  // Arbitrary value.
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic hold_n,
  input  wire logic wp_n,
  output logic      miso,
  output logic      miso_oe,
  output logic      write_latch_flag
);
  import nvm_spi_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  logic [1:0]              rst_sync;
  logic                    rst_n;
  logic [1:0]              cs_sync, clk_sync, din_sync, hold_sync, wp_sync;
  logic                    cs_s, clk_s, din_s, hold_s, wp_s, clk_q;
  logic                    clk_rise, clk_fall, byte_done, deselect;
  logic [2:0]              bit_cnt_reg;
  logic [6:0]              rx_reg;
  logic [7:0]              in_byte, cmd_reg, out_reg, status_byte;
  logic [1:0]              addr_cnt_reg, id_idx_reg;
  logic [23:0]             addr_reg, addr_full;
  logic [ADDR_W-1:0]       mem_idx;
  logic                    mem_we, write_done_reg, prot_en_reg;
  logic [1:0]              blk_reg;
  logic                    miso_reg, miso_oe_reg, latch_reg;
  port_state_t             state_reg;
  logic [7:0]              mem [DEPTH];

  function automatic logic [7:0] ident_byte(input logic [1:0] idx);
    case (idx)
      2'h0:    ident_byte = IDENT_VAL[23:16];
      2'h1:    ident_byte = IDENT_VAL[15:8];
      default: ident_byte = IDENT_VAL[7:0];
    endcase
  endfunction : ident_byte

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Every pin is asynchronous to mclk; only the second stage is read.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_sync   <= 2'h3;
      clk_sync  <= 2'h0;
      din_sync  <= 2'h0;
      hold_sync <= 2'h3;
      wp_sync   <= 2'h3;
      clk_q     <= 1'b0;
    end
    else
    begin
      cs_sync   <= {cs_sync[0], cs_n};
      clk_sync  <= {clk_sync[0], sclk};
      din_sync  <= {din_sync[0], mosi};
      hold_sync <= {hold_sync[0], hold_n};
      wp_sync   <= {wp_sync[0], wp_n};
      clk_q     <= clk_sync[1];
    end
  end
  assign cs_s   = cs_sync[1];
  assign clk_s  = clk_sync[1];
  assign din_s  = din_sync[1];
  assign hold_s = hold_sync[1];
  assign wp_s   = wp_sync[1];

  // Edges count only while selected and not paused, so a pause freezes the whole transfer except the output enable.
  assign clk_rise  = !cs_s && hold_s && clk_s && !clk_q;
  assign clk_fall  = !cs_s && hold_s && !clk_s && clk_q;
  assign deselect  = cs_s && hold_s;
  assign byte_done = clk_rise && (bit_cnt_reg == `BYTE_LAST_BIT);
  assign in_byte   = {rx_reg, din_s};
  assign addr_full = {addr_reg[15:0], in_byte};
  assign mem_idx   = (state_reg == ST_WDATA) ? addr_reg[ADDR_W-1:0] : addr_full[ADDR_W-1:0];
  assign mem_we    = byte_done && (state_reg == ST_WDATA) && latch_reg;
  assign status_byte = `SR_FIXED_VALUE | {prot_en_reg, 3'h0, blk_reg, latch_reg, 1'b0};

  // Mode 0 and mode 3 differ only in the idle clock level; a leading fall in mode 3
  // precedes any output phase and so does nothing.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg    <= ST_CMD;
      bit_cnt_reg  <= 3'h0;
      rx_reg       <= 7'h0;
      cmd_reg      <= 8'h0;
      addr_cnt_reg <= 2'h0;
      addr_reg     <= 24'h0;
      out_reg      <= 8'h0;
      id_idx_reg   <= 2'h0;
    end
    else if (deselect)
    begin
      state_reg    <= ST_CMD;
      bit_cnt_reg  <= 3'h0;
      addr_cnt_reg <= 2'h0;
    end
    else if (clk_fall && (state_reg == ST_RDATA))
      out_reg <= {out_reg[6:0], 1'b0};
    else if (clk_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= in_byte[6:0];
      if (byte_done)
      begin
        case (state_reg)
          ST_CMD:
          begin
            cmd_reg <= in_byte;
            case (in_byte)
              `CMD_READ_MEM, `CMD_FAST_READ, `CMD_WRITE_MEM: state_reg <= ST_ADDR;
              `CMD_WRITE_STATUS: state_reg <= ST_WSTAT;
              `CMD_READ_STATUS:
              begin
                state_reg <= ST_RDATA;
                out_reg   <= status_byte;
              end
              `CMD_READ_IDENT:
              begin
                state_reg  <= ST_RDATA;
                out_reg    <= ident_byte(2'h0);
                id_idx_reg <= 2'h1;
              end
              default: state_reg <= ST_IGNORE;
            endcase
          end
          ST_ADDR:
          begin
            addr_reg     <= addr_full;
            addr_cnt_reg <= addr_cnt_reg + 2'h1;
            if (addr_cnt_reg == `ADDR_BYTES - 2'h1)
            begin
              if (cmd_reg == `CMD_WRITE_MEM)
                state_reg <= ST_WDATA;
              else if (cmd_reg == `CMD_FAST_READ)
                state_reg <= ST_DUMMY;
              else
              begin
                state_reg <= ST_RDATA;
                out_reg   <= mem[mem_idx];
                addr_reg  <= {{(24 - ADDR_W){1'b0}}, mem_idx + ADDR_W'(1)};
              end
            end
          end
          ST_DUMMY, ST_RDATA:
          begin
            state_reg <= ST_RDATA;
            if (state_reg == ST_RDATA && cmd_reg == `CMD_READ_STATUS)
              out_reg <= status_byte;
            else if (state_reg == ST_RDATA && cmd_reg == `CMD_READ_IDENT)
            begin
              out_reg    <= ident_byte(id_idx_reg);
              id_idx_reg <= (id_idx_reg == 2'h2) ? 2'h0 : id_idx_reg + 2'h1;
            end
            else
            begin
              out_reg  <= mem[addr_reg[ADDR_W-1:0]];
              addr_reg <= {{(24 - ADDR_W){1'b0}}, addr_reg[ADDR_W-1:0] + ADDR_W'(1)};
            end
          end
          ST_WDATA: addr_reg <= {{(24 - ADDR_W){1'b0}}, addr_reg[ADDR_W-1:0] + ADDR_W'(1)};
          ST_WSTAT: state_reg <= ST_IGNORE;
          ST_IGNORE: state_reg <= ST_IGNORE;
          default: state_reg <= ST_IGNORE;
        endcase
      end
    end
  end

  // The array has no reset, as nonvolatile content should not be lost on a port reset.
  always_ff @(posedge mclk)
  begin
    if (rst_n && mem_we)
      mem[mem_idx] <= in_byte;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch_reg      <= 1'b0;
      write_done_reg <= 1'b0;
      prot_en_reg    <= 1'b0;
      blk_reg        <= 2'h0;
    end
    else if (deselect)
    begin
      write_done_reg <= 1'b0;
      if (write_done_reg)
        latch_reg <= 1'b0;
    end
    else if (byte_done)
    begin
      if (state_reg == ST_CMD && in_byte == `CMD_WRITE_LATCH_SET)
        latch_reg <= 1'b1;
      else if (state_reg == ST_CMD && in_byte == `CMD_WRITE_LATCH_CLR)
        latch_reg <= 1'b0;
      if ((state_reg == ST_WDATA || state_reg == ST_WSTAT) && latch_reg)
        write_done_reg <= 1'b1;
      if (state_reg == ST_WSTAT && latch_reg && wp_s)
      begin
        prot_en_reg <= in_byte[`SR_PROT_EN_BIT];
        blk_reg     <= {in_byte[`SR_BLK1_BIT], in_byte[`SR_BLK0_BIT]};
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      miso_reg    <= 1'b0;
      miso_oe_reg <= 1'b0;
    end
    else
    begin
      miso_oe_reg <= !cs_s && hold_s && (state_reg == ST_RDATA);
      if (clk_fall && state_reg == ST_RDATA)
        miso_reg <= out_reg[7];
    end
  end

  assign miso             = miso_reg;
  assign miso_oe          = miso_oe_reg;
  assign write_latch_flag = latch_reg;

  a_standby_float: assert property (@(posedge mclk) disable iff (!rst_n) cs_s |=> !miso_oe)
    else $error("output driven while deselected");
  a_pause_float: assert property (@(posedge mclk) disable iff (!rst_n) !hold_s |=> !miso_oe)
    else $error("output driven during pause");
  a_out_on_fall: assert property (@(posedge mclk) disable iff (!rst_n) $changed(miso) |-> $past(clk_fall))
    else $error("output changed without a falling clock edge");
  a_fresh_command: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(cs_s) && hold_s |=> state_reg == ST_CMD && bit_cnt_reg == 3'h0)
    else $error("deselect did not reset the transfer");
  a_protect_status: assert property (@(posedge mclk) disable iff (!rst_n)
    byte_done && state_reg == ST_WSTAT && !wp_s |=> $stable(blk_reg) && $stable(prot_en_reg))
    else $error("status written while write-protected");
  a_latch_cleared: assert property (@(posedge mclk) disable iff (!rst_n)
    deselect && write_done_reg |=> !write_latch_flag)
    else $error("write latch survived a completed write");
  a_latch_set: assert property (@(posedge mclk) disable iff (!rst_n)
    byte_done && state_reg == ST_CMD && in_byte == `CMD_WRITE_LATCH_SET |=> write_latch_flag[*2])
    else $error("latch-set command did not set the latch");
  a_write_commit: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_we |=> mem[$past(mem_idx)] == $past(in_byte))
    else $error("written byte not committed at once");
  a_drive_read_only: assert property (@(posedge mclk) disable iff (!rst_n)
    miso_oe |-> $past(state_reg) == ST_RDATA)
    else $error("output driven outside a read");

endmodule : serial_nv_memory_spi_port

`default_nettype wire

/* verification/spi_master_model.sv */
// Bus master model for the serial memory port: select, serial clock, data, pause and write-protect.
// Assumes pins are sampled on mclk; each serial clock half period is four mclk cycles (160 ns period).
`default_nettype none

module spi_master_model (
  input  wire logic mclk,
  input  wire logic miso,
  input  wire logic miso_oe,
  output logic      cs_n,
  output logic      sclk,
  output logic      mosi,
  output logic      hold_n,
  output logic      wp_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic mode3     = 1'b0;
  int   pause_bit = -1;
  int   cut_bit   = -1;
  logic held_oe   = 1'b0;
  logic q_last    = 1'b0;

  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask : tk

  task automatic sel();
    sclk <= mode3;
    tk(4);
    cs_n <= 1'b0;
    tk(4);
  endtask : sel

  task automatic desel();
    sclk <= mode3;
    tk(4);
    cs_n <= 1'b1;
    tk(8);
  endtask : desel

  // A released output reads as the inverse of its last level, so floating can match only a byte whose bits alternate.
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      if (i == cut_bit)
        return;
      sclk <= 1'b0;
      mosi <= tx[i];
      tk(4);
      if (i == pause_bit)
      begin
        hold_n <= 1'b0;
        tk(4);
        sclk <= 1'b1;
        tk(4);
        sclk <= 1'b0;
        tk(3);
        @(negedge mclk);
        held_oe = miso_oe;
        @(posedge mclk);
        hold_n <= 1'b1;
        tk(4);
      end
      sclk <= 1'b1;
      tk(3);
      @(negedge mclk);
      q_last = miso_oe ? miso : ~q_last;
      rx[i] = q_last;
      @(posedge mclk);
    end
  endtask : xb
endmodule : spi_master_model

`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the serial memory port, driving it through the bus master model.
// Assumes a reference array in the bench predicts every memory read.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] IDENT = 24'h3C5A96;  // Arbitrary value.
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cs_n, sclk, mosi, hold_n, wp_n, miso, miso_oe, write_latch_flag;
  logic [31:0] lfsr = 32'h9155CE04;
  logic [7:0]  mem [int];
  logic [7:0]  sr = 8'h00;
  logic [7:0]  r;
  logic        latch = 1'b0;
  logic [23:0] a;
  int          bad_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  serial_nv_memory_spi_port #(.IDENT_VAL(IDENT)) uut (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe), .write_latch_flag(write_latch_flag));
  spi_master_model m (.mclk(mclk), .miso(miso), .miso_oe(miso_oe), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .hold_n(hold_n), .wp_n(wp_n));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  function automatic logic [7:0] stat(input logic [7:0] s, input logic l);
    return {s[7], 1'b1, 2'b00, s[3:2], l, 1'b0};
  endfunction : stat

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic cmd(input logic [7:0] op);
    m.sel();
    m.xb(op, r);
    m.desel();
    if (op == 8'h06 || op == 8'h04)
      latch = (op == 8'h06);
  endtask : cmd

  task automatic xa(input logic [23:0] ad);
    m.xb(ad[23:16], r);
    m.xb(ad[15:8], r);
    m.xb(ad[7:0], r);
  endtask : xa

  // The reference array only follows a write while the latch is set.
  task automatic wr(input logic [23:0] ad, input int n);
    m.sel();
    m.xb(8'h02, r);
    xa(ad);
    for (int k = 0; k < n; k++)
    begin
      lfsr = nxt(lfsr);
      m.xb(lfsr[7:0], r);
      if (latch)
        mem[(ad + k) % 131072] = lfsr[7:0];
    end
    m.desel();
    latch = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] op, input logic [23:0] ad, input int n);
    m.sel();
    m.xb(op, r);
    xa(ad);
    if (op == 8'h0B)
      m.xb(8'h00, r);
    for (int k = 0; k < n; k++)
    begin
      m.xb(8'h00, r);
      chk(r, mem[(ad + k) % 131072]);
    end
    m.desel();
  endtask : rd

  task automatic rb(input logic [7:0] op, input logic [23:0] e, input int n);
    m.sel();
    m.xb(op, r);
    for (int k = 0; k < n; k++)
    begin
      m.xb(8'h00, r);
      chk(r, e[8 * (n - 1 - k) +: 8]);
    end
    m.desel();
  endtask : rb

  task automatic wst(input logic [7:0] v);
    m.sel();
    m.xb(8'h01, r);
    m.xb(v, r);
    m.desel();
    if (latch && wp_n)
      sr = v;
    latch = 1'b0;
  endtask : wst

  initial
  begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({7'h00, write_latch_flag}, 8'h00);
    m.xb(8'h06, r);
    chk({6'h00, miso_oe, write_latch_flag}, 8'h00);
    m.cut_bit = 3;
    cmd(8'h06);
    m.cut_bit = -1;
    latch = 1'b0;
    chk({7'h00, write_latch_flag}, 8'h00);
    cmd(8'h06);
    chk({7'h00, write_latch_flag}, 8'h01);
    cmd(8'h04);
    chk({7'h00, write_latch_flag}, 8'h00);
    cmd(8'h06);
    wr(24'h01FFFF, 2);
    chk({7'h00, write_latch_flag}, 8'h00);
    wr(24'h01FFFF, 1);
    rd(8'h03, 24'h01FFFF, 2);
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      a = lfsr[23:0];
      m.mode3 = i[0];
      cmd(8'h06);
      wr(a, 3);
      m.pause_bit = (i == 2) ? 4 : -1;
      rd(i[1] ? 8'h0B : 8'h03, a ^ 24'hFE0000, 3);
      if (i == 2)
        chk({7'h00, m.held_oe}, 8'h00);
    end
    m.mode3 = 1'b0;
    cmd(8'h06);
    wst(8'h8C);
    rb(8'h05, {16'h0000, stat(sr, latch)}, 1);
    m.wp_n <= 1'b0;
    cmd(8'h06);
    wst(8'h00);
    cmd(8'h06);
    rb(8'h05, {16'h0000, stat(sr, latch)}, 1);
    wr(24'h00ABCD, 1);
    rd(8'h03, 24'h00ABCD, 1);
    rb(8'h9F, IDENT, 3);
    m.sel();
    m.xb(8'hA7, r);
    m.xb(8'h00, r);
    chk({7'h00, miso_oe}, 8'h00);
    m.desel();
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
